// ---- shared/scurve_pkg.sv ----
// constants shared by the s-curve step profile generator
package scurve_pkg;

    // clock and profile tick
    localparam logic [63:0] CLK_HZ       = 64'h0000_0000_02FA_F080;
    localparam int unsigned CLK_MHZ      = 50;
    localparam int unsigned TICK_US      = 1000;
    localparam int unsigned TICK_CYCLES  = TICK_US * CLK_MHZ;

    // fixed point: speed and acceleration are kept scaled by this factor
    localparam logic [63:0] FX_SCALE     = 64'h0000_0000_0001_86A0;
    localparam logic [63:0] MS_PER_S     = 64'h0000_0000_0000_03E8;
    localparam logic [63:0] STEP_TH      = CLK_HZ * FX_SCALE;
    localparam logic [63:0] BRAKE_LIN    = 64'h0000_0000_0000_0002 * MS_PER_S * FX_SCALE * FX_SCALE;
    localparam logic [63:0] BRAKE_SCV    = MS_PER_S * FX_SCALE * FX_SCALE;
    localparam logic [15:0] JERK_MAX     = 16'h1388;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_VSTART    = 8'h04;
    localparam logic [7:0] OFS_VPROG     = 8'h08;
    localparam logic [7:0] OFS_ACCEL     = 8'h0C;
    localparam logic [7:0] OFS_DECEL     = 8'h10;
    localparam logic [7:0] OFS_JERK      = 8'h14;
    localparam logic [7:0] OFS_LENGTH    = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1C;
    localparam logic [7:0] OFS_COUNT     = 8'h20;

    // control bits
    localparam int unsigned CTRL_GO      = 0;
    localparam int unsigned CTRL_ABORT   = 1;

    // status fields
    localparam int unsigned STS_BUSY     = 0;
    localparam int unsigned STS_STATE    = 1;
    localparam int unsigned STS_RAMP     = 4;
    localparam int unsigned STS_TRAP     = 6;

    // reset values
    localparam logic [31:0] RST_VSTART   = 32'h0000_0000;
    localparam logic [31:0] RST_VPROG    = 32'h0000_0000;
    localparam logic [15:0] RST_ACCEL    = 16'h0000;
    localparam logic [15:0] RST_DECEL    = 16'h0000;
    localparam logic [15:0] RST_JERK     = 16'h0000;
    localparam logic [31:0] RST_LENGTH   = 32'h0000_0000;

endpackage

// ---- verif/scurve_host_model.sv ----
// host model: classic wishbone master that programs the move parameters
`timescale 1ns/1ps
module scurve_host_model (
    // clock
    input  wire logic        clk_i,
    // wishbone master
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [7:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_i
);
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    // values go out already in the device's scaled units, no conversion here
    task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= dat;
        @(posedge clk_i);
        while (wb_ack_i !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= 1'b0;
        // released data lines must not keep showing the last word
        wb_dat_o <= ~dat;
    endtask
endmodule

// ---- verif/scurve_step_profile_generator_checker.sv ----
// port checker for the s-curve step profile generator
`timescale 1ns/1ps
module scurve_step_profile_generator_checker
    import scurve_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // motor side
    input wire logic        step_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wire logic bus_req  = wb_cyc_i && wb_stb_i;
    wire logic ctrl_wr  = bus_req && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0];
    wire logic go_req   = ctrl_wr && wb_dat_i[CTRL_GO];
    wire logic stop_req = ctrl_wr && wb_dat_i[CTRL_ABORT];

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (bus_req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked in the next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(bus_req))
        else $error("ack without a request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    step_single_a: assert property (step_o |=> !step_o)
        else $error("step pulse wider than one cycle");
    step_in_move_a: assert property (step_o |-> $past(busy_o))
        else $error("step pulse outside a move");
    busy_start_a: assert property ($rose(busy_o) |-> $past(go_req) || $past(go_req, 2))
        else $error("move started without a go write");
    busy_end_a: assert property ($fell(busy_o) |-> step_o || $past(stop_req) || $past(stop_req, 2))
        else $error("move ended without its last step");

    move_seen_c: cover property ($rose(busy_o));
    last_step_c: cover property ($fell(busy_o) && step_o);
    abort_seen_c: cover property (stop_req && busy_o);
endmodule

bind scurve_step_profile_generator scurve_step_profile_generator_checker u_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .step_o(step_o), .busy_o(busy_o));

// ---- verif/tb_scurve_step_profile_generator.sv ----
// self-checking bench for the s-curve step profile generator
`timescale 1ns/1ps
module tb_scurve_step_profile_generator
    import scurve_pkg::*;
;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        step;
    logic        busy;
    logic [15:0] rnd = 16'h0023;
    logic [31:0] shadow [7];
    int          err_count = 0;
    int          tests_run = 0;
    int          ncyc = 0;
    int          nsteps = 0;

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // short tick keeps the per-tick math but makes ramps fit the run
    scurve_step_profile_generator #(.TICK_CYC(50)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .step_o(step), .busy_o(busy));

    scurve_host_model u_host (
        .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));

    always @(posedge clk_i)
    begin
        ncyc <= ncyc + 1;
        if (step === 1'b1)
            nsteps <= nsteps + 1;
        if (ncyc == 99000)
        begin
            err_count++;
            end_sim();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s,
                                          input logic [31:0] m);
        logic [31:0] r;
        for (int b = 0; b < 4; b++)
            r[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
        return r & m;
    endfunction

    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.access(1'b1, a, 4'hF, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        u_host.access(1'b0, a, 4'hF, 32'h0000_0000, q);
    endtask

    // mode 1 repeats go mid-move, mode 2 aborts mid-move
    task automatic move(input string nm, input logic [15:0] j, input logic [15:0] dc, input logic [31:0] len,
                        input int mode, output int t, output logic tp);
        logic [31:0] q;
        wr(OFS_JERK, {16'h0000, j});
        wr(OFS_DECEL, {16'h0000, dc});
        wr(OFS_LENGTH, len);
        nsteps = 0;
        t = 0;
        wr(OFS_CTRL, 32'h0000_0001);
        @(posedge clk_i);
        while (busy === 1'b1)
        begin
            if (t == 2000 && mode != 0)
                wr(OFS_CTRL, mode == 1 ? 32'h0000_0001 : 32'h0000_0002);
            @(posedge clk_i);
            t++;
        end
        repeat (3) @(posedge clk_i);
        check(busy === 1'b0, "busy after move end");
        rd(OFS_COUNT, q);
        if (mode == 2)
            check(nsteps < len && q === nsteps, "abort step count");
        else
            check(nsteps === len && (len == 0 || q === len), "step count");
        rd(OFS_STATUS, q);
        tp = q[STS_TRAP];
        $display("test %s done after %0d cycles", nm, t);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        logic [31:0] q;
        logic [31:0] wd;
        logic        tp;
        int          k;
        int          t0;
        int          t1;
        int          t2;
        int          t3;
        int          t4;
        for (int i = 0; i < 7; i++)
            shadow[i] = 32'h0000_0000;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            rd(8'(i * 4), q);
            check(q === 32'h0000_0000, "reset value");
        end
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            k = 1 + rnd[7:4] % 6;
            wd = {rnd, lfsr(rnd)};
            u_host.access(1'b1, 8'(k * 4), rnd[3:0], wd, q);
            shadow[k] = merge(shadow[k], wd, rnd[3:0], (k >= 3 && k <= 5) ? 32'h0000_FFFF : 32'h00FF_FFFF);
            rd(8'(k * 4), q);
            check(q === shadow[k], "register readback");
        end
        wr(OFS_JERK, 32'h0000_FFFF);
        rd(OFS_JERK, q);
        check(q === 32'h0000_FFFF, "jerk stored as written");
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, q);
        check(q === 32'h0000_0000, "unmapped read");
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        rd(OFS_STATUS, q);
        check(q === 32'h0000_0000, "status is read only");
        $display("test registers done");
        wr(OFS_VSTART, 32'h0000_C350);
        wr(OFS_VPROG, 32'h0003_0D40);
        wr(OFS_ACCEL, 32'h0000_C350);
        move("linear", 16'h0000, 16'hC350, 32'h0000_001E, 0, t0, tp);
        check(tp === 1'b1, "long move cruises");
        move("jerk max", JERK_MAX, 16'hC350, 32'h0000_001E, 0, t1, tp);
        move("jerk over range", 16'hFFFF, 16'hC350, 32'h0000_001E, 0, t2, tp);
        check(t2 == t1, "jerk over range acts as max");
        check(t1 >= t0, "linear ramp is fastest");
        move("jerk low", 16'h00C8, 16'hC350, 32'h0000_001E, 0, t3, tp);
        check(t3 > t1, "lower jerk ramps longer");
        move("slow decel", 16'h00C8, 16'h0EA6, 32'h0000_001E, 0, t4, tp);
        check(t4 > t3, "decel jerk follows decel");
        move("triangle", 16'h00C8, 16'hC350, 32'h0000_0006, 0, t4, tp);
        check(tp === 1'b0, "short move has no cruise");
        move("zero length", 16'h0000, 16'hC350, 32'h0000_0000, 0, t4, tp);
        move("go while busy", 16'h0000, 16'hC350, 32'h0000_001E, 1, t4, tp);
        move("abort", 16'h00C8, 16'hC350, 32'h0000_001E, 2, t4, tp);
        end_sim();
    end
endmodule

// ---- verilog/scurve_step_profile_generator.sv ----
// step-rate profile generator with s-curve acceleration and a wishbone register port
`timescale 1ns/1ps

//Behaviour
//- A jerk value of 1 to 5000 makes acceleration ramp gradually, giving an S-shaped speed change.
//- Physical jerk equals the jerk value divided by 100 times the acceleration in steps per second squared.
//- The jerk value is a scaled unitless 16-bit field that software writes and the block stores as is.
//- Deceleration uses its own jerk rate scaled the same way from the deceleration value.
//- A jerk value of zero gives constant acceleration and a linear speed change.
//- With jerk active each ramp is triangular or trapezoidal, ramping up, holding and ramping down.
//- A ramp becomes trapezoidal when acceleration reaches its limit before half the speed change.
//- A trapezoidal profile cruises at programmed speed for the steps not used by the two ramps.
//- A triangular profile has no cruise and turns straight from acceleration into deceleration.
//- With jerk active every ramp starts smoothed, but an accel ramp cut by the brake point drops its acceleration straight to zero.
//- Acceleration and deceleration are programmed and used in steps per second per millisecond.
//- The profile is trapezoidal when the move is longer than both ramps together, else triangular.
//- Every s-curve ramp not cut short by the brake point is symmetric about the midpoint of its speed change.
module scurve_step_profile_generator
    import scurve_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned SPD_W    = 24,
    parameter int unsigned LEN_W    = 24
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // motor side
    output logic             step_o,
    output logic             busy_o
);

    localparam int unsigned FXW = 48;
    localparam int unsigned AW  = 40;
    localparam int unsigned TCW = $clog2(TICK_CYC + 1);
    // brake factors follow the real tick length, so a shortened tick still brakes at the right step
    localparam logic [95:0] BRK_LIN = 96'(BRAKE_LIN) * 96'(TICK_CYCLES) / 96'(TICK_CYC);
    localparam logic [95:0] BRK_SCV = 96'(BRAKE_SCV) * 96'(TICK_CYCLES) / 96'(TICK_CYC);

    typedef enum logic [2:0] {ST_IDLE, ST_ACCEL, ST_CRUISE, ST_DECEL, ST_CREEP} state_e;
    typedef enum logic [1:0] {RP_UP, RP_HOLD, RP_DOWN} ramp_e;

    // software registers
    logic [SPD_W-1:0] vstart;
    logic [SPD_W-1:0] vprog;
    logic [15:0]      accel;
    logic [15:0]      decel;
    logic [15:0]      jerk;
    logic [LEN_W-1:0] length;

    // move parameters latched at start
    logic [FXW-1:0]   goal;
    logic [FXW-1:0]   vs_fx;
    logic [AW-1:0]    lim_a;
    logic [AW-1:0]    lim_d;
    logic [AW-1:0]    jinc_a;
    logic [AW-1:0]    jinc_d;
    logic [15:0]      decel_l;
    logic [LEN_W-1:0] len_l;
    logic             jerk_on;

    // profile state
    state_e           state;
    state_e           next_state;
    ramp_e            ramp;
    ramp_e            next_ramp;
    logic [AW-1:0]    acc;
    logic [AW-1:0]    next_acc;
    logic [FXW-1:0]   speed;
    logic [FXW-1:0]   next_speed;
    logic [FXW-1:0]   base;
    logic [FXW-1:0]   next_base;
    logic [FXW-1:0]   half;
    logic [FXW-1:0]   next_half;
    logic [FXW-1:0]   ramp_dv;
    logic [FXW-1:0]   next_ramp_dv;
    logic             trap;
    logic [63:0]      phase;
    logic [LEN_W-1:0] count;
    logic [TCW-1:0]   tick_cnt;

    // bus decode
    wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr       = req & wb_we_i;
    wire [31:0] bmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire        sel_ctrl = wb_adr_i == OFS_CTRL;
    wire        sel_vs   = wb_adr_i == OFS_VSTART;
    wire        sel_vp   = wb_adr_i == OFS_VPROG;
    wire        sel_ac   = wb_adr_i == OFS_ACCEL;
    wire        sel_dc   = wb_adr_i == OFS_DECEL;
    wire        sel_jk   = wb_adr_i == OFS_JERK;
    wire        sel_len  = wb_adr_i == OFS_LENGTH;
    wire        sel_sts  = wb_adr_i == OFS_STATUS;
    wire        sel_cnt  = wb_adr_i == OFS_COUNT;
    wire        go       = wr & sel_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_GO];
    wire        abort    = wr & sel_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_ABORT];

    function automatic logic [31:0] merge(input logic [31:0] old_v);
        return (old_v & ~bmask) | (wb_dat_i & bmask);
    endfunction

    wire [31:0] status_w = {25'h000_0000, trap, ramp, state, busy_o};
    wire [31:0] rd_data  = ({32{sel_vs}}  & 32'(vstart))
                         | ({32{sel_vp}}  & 32'(vprog))
                         | ({32{sel_ac}}  & {16'h0000, accel})
                         | ({32{sel_dc}}  & {16'h0000, decel})
                         | ({32{sel_jk}}  & {16'h0000, jerk})
                         | ({32{sel_len}} & 32'(length))
                         | ({32{sel_sts}} & status_w)
                         | ({32{sel_cnt}} & 32'(count));

    // values taken into the move at start
    // one tick is one millisecond, so an acceleration in steps/s/ms is the speed gain per tick
    wire [15:0]    jerk_c   = (jerk > JERK_MAX) ? JERK_MAX : jerk;
    wire [FXW-1:0] goal_in  = FXW'(64'(vprog) * FX_SCALE);
    wire [FXW-1:0] vs_in    = FXW'(64'(vstart) * FX_SCALE);
    wire [AW-1:0]  lim_a_in = AW'(64'(accel) * FX_SCALE);
    wire [AW-1:0]  lim_d_in = AW'(64'(decel) * FX_SCALE);
    // (J/100)*a*1000 steps/s^3 over one tick, in fixed point, reduces to J*a
    wire [AW-1:0]  jinc_a_in = AW'(jerk_c) * AW'(accel);
    wire [AW-1:0]  jinc_d_in = AW'(jerk_c) * AW'(decel);
    wire [FXW-1:0] half_in  = (goal_in > vs_in) ? (goal_in - vs_in) >> 1 : '0;

    // profile datapath
    wire           tick     = tick_cnt == TCW'(TICK_CYC - 1);
    wire           up       = state == ST_ACCEL;
    wire           ramping  = (state == ST_ACCEL) || (state == ST_DECEL);
    wire [AW-1:0]  lim      = up ? lim_a : lim_d;
    wire [AW-1:0]  jinc     = up ? jinc_a : jinc_d;
    wire [AW-1:0]  acc_up   = jerk_on ? acc + jinc : lim;
    wire [FXW-1:0] gained   = up ? speed - base : base - speed;
    wire [FXW-1:0] left     = up ? goal - speed : speed - vs_fx;
    wire [LEN_W-1:0] rem    = len_l - count;

    // brake point: stopping distance from the present speed against steps left;
    // the s-curve case assumes half the programmed deceleration on average
    wire [95:0]    v_sq     = 96'(speed) * 96'(speed);
    wire [95:0]    vs_sq    = 96'(vs_fx) * 96'(vs_fx);
    wire [95:0]    brake_k  = jerk_on ? BRK_SCV : BRK_LIN;
    wire [95:0]    stop_d   = 96'(rem) * 96'(decel_l) * brake_k;
    wire           brake    = (v_sq - vs_sq) >= stop_d;

    // step generator
    wire [63:0]    ph_sum   = phase + 64'(speed);
    wire           running  = state != ST_IDLE;
    wire           fire     = running && (ph_sum >= STEP_TH);
    wire           last     = fire && (count == len_l - LEN_W'(1));

    always_comb
    begin
        next_state   = state;
        next_ramp    = ramp;
        next_acc     = acc;
        next_speed   = speed;
        next_base    = base;
        next_half    = half;
        next_ramp_dv = ramp_dv;
        if (abort || last)
        begin
            next_state = ST_IDLE;
            next_acc   = '0;
            next_speed = '0;
        end
        else if (go && state == ST_IDLE)
        begin
            if (length != '0)
            begin
                next_state = ST_ACCEL;
            end
            next_ramp    = RP_UP;
            next_acc     = '0;
            next_speed   = vs_in;
            next_base    = vs_in;
            next_half    = half_in;
            next_ramp_dv = '0;
        end
        else if (tick && ((up && brake) || (state == ST_CRUISE && brake)))
        begin
            // turning from accel straight into decel leaves no cruise
            next_state   = ST_DECEL;
            next_ramp    = RP_UP;
            next_acc     = '0;
            next_base    = speed;
            next_half    = (speed - vs_fx) >> 1;
            next_ramp_dv = '0;
        end
        else if (tick && ramping)
        begin
            unique case (ramp)
                RP_UP:
                begin
                    if (acc_up >= lim)
                    begin
                        // limit reached before mid-speed: trapezoidal ramp
                        next_acc     = lim;
                        next_ramp_dv = gained;
                        next_ramp    = RP_HOLD;
                    end
                    else if (gained >= half)
                    begin
                        // mid-speed reached first: triangular ramp
                        next_acc     = acc_up;
                        next_ramp_dv = gained;
                        next_ramp    = RP_DOWN;
                    end
                    else
                    begin
                        next_acc = acc_up;
                    end
                end
                RP_HOLD:
                begin
                    // ramp down over the same speed span the ramp up took
                    if (jerk_on && left <= ramp_dv)
                    begin
                        next_ramp = RP_DOWN;
                    end
                end
                RP_DOWN:
                begin
                    // hold once at or below one jerk step so the goal is always reached
                    next_acc = (acc > jinc) ? acc - jinc : acc;
                end
            endcase
            if (up)
            begin
                if (speed + FXW'(next_acc) >= goal)
                begin
                    next_speed = goal;
                    next_state = ST_CRUISE;
                end
                else
                begin
                    next_speed = speed + FXW'(next_acc);
                end
            end
            else if (left <= FXW'(next_acc))
            begin
                // start speed reached with steps left: finish at start speed
                next_speed = vs_fx;
                next_state = ST_CREEP;
            end
            else
            begin
                next_speed = speed - FXW'(next_acc);
            end
        end
    end

    // register file
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            vstart <= SPD_W'(RST_VSTART);
            vprog  <= SPD_W'(RST_VPROG);
            accel  <= RST_ACCEL;
            decel  <= RST_DECEL;
            jerk   <= RST_JERK;
            length <= LEN_W'(RST_LENGTH);
        end
        else if (wr)
        begin
            if (sel_vs)
                vstart <= SPD_W'(merge(32'(vstart)));
            if (sel_vp)
                vprog <= SPD_W'(merge(32'(vprog)));
            if (sel_ac)
                accel <= 16'(merge({16'h0000, accel}));
            if (sel_dc)
                decel <= 16'(merge({16'h0000, decel}));
            if (sel_jk)
                jerk <= 16'(merge({16'h0000, jerk}));
            if (sel_len)
                length <= LEN_W'(merge(32'(length)));
        end
    end

    // bus answer: one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_data : '0;
        end
    end

    // latch the move so software may reprogram during it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            goal    <= '0;
            vs_fx   <= '0;
            lim_a   <= '0;
            lim_d   <= '0;
            jinc_a  <= '0;
            jinc_d  <= '0;
            decel_l <= '0;
            len_l   <= '0;
            jerk_on <= 1'b0;
        end
        else if (go && state == ST_IDLE)
        begin
            goal    <= goal_in;
            vs_fx   <= vs_in;
            lim_a   <= lim_a_in;
            lim_d   <= lim_d_in;
            jinc_a  <= jinc_a_in;
            jinc_d  <= jinc_d_in;
            decel_l <= decel;
            len_l   <= length;
            jerk_on <= jerk_c != 16'h0000;
        end
    end

    // profile state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state   <= ST_IDLE;
            ramp    <= RP_UP;
            acc     <= '0;
            speed   <= '0;
            base    <= '0;
            half    <= '0;
            ramp_dv <= '0;
            busy_o  <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            ramp    <= next_ramp;
            acc     <= next_acc;
            speed   <= next_speed;
            base    <= next_base;
            half    <= next_half;
            ramp_dv <= next_ramp_dv;
            busy_o  <= next_state != ST_IDLE;
        end
    end

    // profile kind: set once cruise is entered
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (go && state == ST_IDLE))
            trap <= 1'b0;
        else if (next_state == ST_CRUISE)
            trap <= 1'b1;
    end

    // millisecond tick, restarted with every move
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !running || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + TCW'(1);
    end

    // step pulses from a phase accumulator of speed against the clock rate
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (go && state == ST_IDLE))
        begin
            phase  <= '0;
            count  <= '0;
            step_o <= 1'b0;
        end
        else if (running)
        begin
            phase  <= fire ? ph_sum - STEP_TH : ph_sum;
            count  <= fire ? count + LEN_W'(1) : count;
            step_o <= fire;
        end
        else
        begin
            step_o <= 1'b0;
        end
    end

endmodule
